// *** bench/bfs_ontime_model.sv ***
/*
 * far-side model: the adaptive on-time generator and low-side gate.
 * assumes the sequencer's clock; answers each on-time request after
 * TON cycles with a one-cycle done pulse.
 */
`timescale 1ns/1ns
module bfs_ontime_model #(
    parameter int TON = 4
) (
    input  wire logic clk_i,      // clock
    input  wire logic arst_n_i,   // async reset, low
    input  wire logic ton_req_i,  // on-time request pulse
    input  wire logic hs_en_i,    // high side may switch
    input  wire logic ls_force_i, // low side held on
    output logic      ton_done_o, // on-time expired pulse
    output logic      ls_on_o     // low side conducting
);
    int cnt;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt        <= 0;
            ton_done_o <= 1'b0;
        end else begin
            ton_done_o <= (cnt == 1);
            if (ton_req_i) begin
                cnt <= TON;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end

    // low side is off while the high-side on-time runs
    assign ls_on_o = (hs_en_i | ls_force_i) & (cnt == 0);
endmodule

// *** bench/bfs_sequencer_tb.sv ***
/*
 * self-checking bench for the fault sequencer with shortened delays.
 * assumes the on-time model answers requests; comparators are levels
 * driven at the falling edge.
 */
`timescale 1ns/1ns
module bfs_sequencer_tb;
    localparam int SS  = 50;
    localparam int PGD = 40;
    localparam int HIC = 200;
    localparam int TON = 4;
    logic clk, arst_n, ce, en, bias_ok, main_ok, otp;
    logic ssdone, uv, ov, out_of_bounds_clamp, fb_low, neg_lim, ls_on, ton_done;
    logic hs_en, ls_force, ton_req, fccm, dis_sw, ss_dis, pg;
    int   miscompares  = 0;
    int   total_checks = 0;
    int   pulses       = 0;
    int   p0;

    bfs_sequencer #(.HICCUP_CYC(HIC), .SS_CYC(SS), .PGD_CYC(PGD))
    u_bfs_sequencer (
        .clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .en_i(en),
        .bias_ok_i(bias_ok), .main_ok_i(main_ok), .otp_i(otp),
        .fb_ssdone_i(ssdone), .fb_uv_i(uv), .fb_ov_i(ov),
        .fb_oob_i(out_of_bounds_clamp), .fb_low_i(fb_low), .neg_lim_i(neg_lim),
        .ls_on_i(ls_on), .ton_done_i(ton_done), .hs_en_o(hs_en),
        .ls_force_o(ls_force), .ton_req_o(ton_req), .fccm_o(fccm),
        .dis_sw_o(dis_sw), .ss_dis_o(ss_dis), .pg_output_o(pg));

    bfs_ontime_model #(.TON(TON)) u_bfs_ontime_model (
        .clk_i(clk), .arst_n_i(arst_n), .ton_req_i(ton_req),
        .hs_en_i(hs_en), .ls_force_i(ls_force),
        .ton_done_o(ton_done), .ls_on_o(ls_on));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // sampled away from the launching edge
    always @(negedge clk) begin
        if (ton_req === 1'b1) begin
            pulses++;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0:       return hs_en;
            1:       return pg;
            default: return ls_force;
        endcase
    endfunction

    // bounded wait; running out ends the run as a failure
    task automatic wait_for(input int s, input logic v, input int max);
        int n;
        n = 0;
        while (pick(s) !== v && n < max) begin
            cyc(1);
            n++;
        end
        chk(pick(s), v);
        if (pick(s) !== v) begin
            results();
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(pg, 1'b0);
        chk(ss_dis, 1'b1);
        chk({hs_en, ls_force, ton_req, fccm}, 4'h0);
    endtask

    task automatic t_powerup();
        en = 1'b1;
        wait_for(0, 1'b1, 10);
        chk(ss_dis, 1'b0);
        cyc(SS + PGD + 10);
        chk(pg, 1'b0);
        ssdone = 1'b1;
        cyc(PGD - 3);
        chk(pg, 1'b0);
        wait_for(1, 1'b1, 10);
    endtask

    task automatic t_retoggle();
        en = 1'b0;
        cyc(5);
        en = 1'b1;
        wait_for(0, 1'b1, 10);
        cyc(SS + PGD - 5);
        chk(pg, 1'b0);
        wait_for(1, 1'b1, 12);
        chk(pg, 1'b1);
    endtask

    task automatic t_oob();
        out_of_bounds_clamp = 1'b1;
        cyc(30);
        chk({fccm, hs_en, pg}, 3'h7);
        out_of_bounds_clamp = 1'b0;
        cyc(5);
        chk({fccm, hs_en, pg}, 3'h3);
    endtask

    task automatic t_neglim(input logic expect_pulse);
        p0 = pulses;
        neg_lim = 1'b1;
        cyc(2);
        neg_lim = 1'b0;
        cyc(TON + 10);
        chk(pulses - p0, {31'h0, expect_pulse});
    endtask

    task automatic t_uv_window();
        uv = 1'b1;
        cyc(10);
        uv = 1'b0;
        cyc(5);
        chk(pg, 1'b1);
        uv = 1'b1;
        cyc(600);
        chk({hs_en, pg}, 2'h2);
        uv = 1'b0;
        cyc(3);
        uv = 1'b1;
        cyc(600);
        chk(hs_en, 1'b1);
        uv = 1'b0;
        cyc(5);
        chk(pg, 1'b0);
    endtask

    task automatic t_hiccup();
        uv = 1'b1;
        cyc(670);
        chk(hs_en, 1'b1);
        wait_for(0, 1'b0, 20);
        uv = 1'b0;
        cyc(HIC - 10);
        chk(hs_en, 1'b0);
        wait_for(0, 1'b1, 20);
        // long enough to expire had undervoltage counted during soft-start
        uv = 1'b1;
        cyc(SS + 660);
        chk({hs_en, pg}, 2'h2);
        uv = 1'b0;
        cyc(5);
    endtask

    task automatic t_ovp();
        ov = 1'b1;
        cyc(30);
        chk({hs_en, ls_force, fccm, pg}, 4'h6);
        t_neglim(1'b1);
        ov = 1'b0;
        uv = 1'b1;
        cyc(670);
        chk(ls_force, 1'b1);
        wait_for(2, 1'b0, 30);
        uv = 1'b0;
        cyc(HIC + 50);
        chk({hs_en, ls_force}, 2'h0);
    endtask

    task automatic t_discharge(input int k);
        fb_low = 1'b0;
        case (k)
            0:       en = 1'b0;
            1:       otp = 1'b1;
            2:       bias_ok = 1'b0;
            default: main_ok = 1'b0;
        endcase
        cyc(5);
        chk({dis_sw, ls_force}, 2'h2);
        chk({hs_en, ss_dis}, 2'h1);
        fb_low = 1'b1;
        cyc(5);
        chk(dis_sw, 1'b0);
        if (k == 0) begin
            t_neglim(1'b0);
        end
        {en, otp, bias_ok, main_ok} = 4'hb;
        wait_for(0, 1'b1, 10);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {arst_n, en, bias_ok, main_ok, otp} = 5'h06;
        {ssdone, uv, ov, out_of_bounds_clamp, fb_low, neg_lim} = 6'h00;
        ce = 1'b1;
        cyc(6);
        t_reset();
        arst_n = 1'b1;
        t_powerup();
        t_oob();
        t_neglim(1'b1);
        t_uv_window();
        t_retoggle();
        t_hiccup();
        t_ovp();
        t_retoggle();
        for (int k = 0; k < 4; k++) begin
            t_discharge(k);
        end
        results();
    end
endmodule

// *** core/bfs_delay.sv ***
/*
 * qualified delay counter: done goes high once cond has held for
 * limit consecutive enabled cycles, and clears as soon as cond drops.
 * assumes cond is already synchronous to clk_i.
 */
`timescale 1ns/1ns
module bfs_delay #(
    parameter int unsigned W = 24
) (
    input  wire logic         clk_i,    // clock
    input  wire logic         arst_n_i, // async reset, low
    input  wire logic         ce_i,     // clock enable
    input  wire logic         cond_i,   // qualifying condition
    input  wire logic [W-1:0] limit_i,  // cycles to qualify
    output logic              done_o    // condition held long enough
);
    logic [W-1:0] cnt;

    if (W < 2) begin : g_bad_width
        $error("bfs_delay: width too small");
    end

    // counter clears whenever its condition drops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt    <= '0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            if (!cond_i) begin
                cnt    <= '0;
                done_o <= 1'b0;
            end else if (cnt + 1'b1 >= limit_i) begin
                done_o <= 1'b1;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule

// *** core/bfs_pkg.sv ***
/*
 * constants for the buck fault protection sequencer: timing figures and
 * the cycle counts derived from them at the 10 MHz clock.
 * assumes a single 10 MHz clock; all analog decisions arrive as
 * comparator levels from outside the clock domain.
 */
package bfs_pkg;
    localparam int unsigned CLK_HZ        = 10000000;
    // times as printed, in nanoseconds
    localparam int unsigned PG_DELAY_NS   = 1060000;
    localparam int unsigned SS_TIME_NS    = 2000000;
    localparam int unsigned PG_GLITCH_NS  = 2000;
    localparam int unsigned UV_DELAY_NS   = 68000;
    localparam int unsigned HICCUP_NS     = 14000000;
    localparam int unsigned CLK_NS        = 1000000000 / CLK_HZ;
    // least times round up to whole cycles
    localparam int unsigned PG_DELAY_CYC  =
        (PG_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SS_TIME_CYC   =
        (SS_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PG_GLITCH_CYC =
        (PG_GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned UV_DELAY_CYC  =
        (UV_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HICCUP_CYC    =
        (HICCUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W         = 24;
    localparam logic        PG_RST        = 1'b0;

    typedef enum logic [5:0] {
        BFS_OFF      = 6'h01,
        BFS_SOFTST   = 6'h02,
        BFS_RUN      = 6'h04,
        BFS_OVP      = 6'h08,
        BFS_HICCUP   = 6'h10,
        BFS_LATCHED  = 6'h20
    } bfs_state_e;
endpackage

// *** core/bfs_sequencer.sv ***
/*
 * fault supervision and start-up sequencing for a synchronous buck stage.
 * assumes comparator and enable levels are asynchronous and pass a
 * two-flop synchroniser here; the on-time pulse and gate drivers are
 * outside and answer the one-cycle requests this block issues.
 */
// Function
// - negative limit in low-side on-time: low off, one on-time, low on
// - power-good rises 1.06 ms after both soft-start ramps finish
// - internal soft-start reported finished after 2 ms
// - external soft-start done when feedback reaches reference minus 50 mV
// - feedback below 80% or above 116% latches power-good low after 2 us; above 116% the overvoltage state drops it at once
// - latched power-good low clears only on enable toggle, supply reset or over-temperature
// - power-good held low once bias valid; monitored after soft-start
// - undervoltage held 68 us shuts down, sleeps 14 ms, restarts
// - undervoltage detection disabled until soft-start completes
// - undervoltage recovery before expiry clears the delay timer
// - overvoltage latches high side off, low side on to negative limit
// - overvoltage cycle ends after 68 us undervoltage, then latches off
// - 5% over reference forces continuous conduction, no fault latched
// - discharge mode: switches off, discharge on until feedback below 90 mV
// - discharge on enable low, over-temperature, bias or main lockout
// - bias lockout shuts off, no latch, restarts above rising level
// - main lockout stops switching, discharges soft-start pin, restarts
// - overheating stops switching, discharges soft-start, restarts fresh
`timescale 1ns/1ns
module bfs_sequencer #(
    parameter int unsigned HICCUP_CYC = bfs_pkg::HICCUP_CYC, // sleep
    parameter int unsigned SS_CYC     = bfs_pkg::SS_TIME_CYC, // ramp
    parameter int unsigned PGD_CYC    = bfs_pkg::PG_DELAY_CYC // pg delay
) (
    input  wire logic clk_i,        // 10 MHz clock
    input  wire logic arst_n_i,     // async reset, low
    input  wire logic ce_i,         // clock enable
    input  wire logic en_i,         // enable pin
    input  wire logic bias_ok_i,    // bias above rising lockout level
    input  wire logic main_ok_i,    // main supply above lockout level
    input  wire logic otp_i,        // over-temperature, with hysteresis
    input  wire logic fb_ssdone_i,  // feedback above reference - 50 mV
    input  wire logic fb_uv_i,      // feedback below 80 % of reference
    input  wire logic fb_ov_i,      // feedback above 116 % of reference
    input  wire logic fb_oob_i,     // feedback above 105 % of reference
    input  wire logic fb_low_i,     // feedback below 90 mV
    input  wire logic neg_lim_i,    // low-side current at negative limit
    input  wire logic ls_on_i,      // low side currently on
    input  wire logic ton_done_i,   // adaptive on-time expired (same clk)
    output logic      hs_en_o,      // high side may switch
    output logic      ls_force_o,   // hold low side on
    output logic      ton_req_o,    // pulse: fire one high-side on-time
    output logic      fccm_o,       // forced continuous conduction
    output logic      dis_sw_o,     // output discharge switch on
    output logic      ss_dis_o,     // discharge soft-start pin
    output logic      pg_output_o   // power-good, high when good
);
    // the hiccup, soft-start and power-good delays must fit the shared counter width and be at least one
    if (HICCUP_CYC >= (1 << bfs_pkg::CNT_W) || HICCUP_CYC < 1) begin : g_bad_hic
        $error("bfs_sequencer: hiccup count out of range");
    end
    if (SS_CYC >= (1 << bfs_pkg::CNT_W) || SS_CYC < 1) begin : g_bad_ss
        $error("bfs_sequencer: soft-start count out of range");
    end
    if (PGD_CYC >= (1 << bfs_pkg::CNT_W) || PGD_CYC < 1) begin : g_bad_pgd
        $error("bfs_sequencer: power-good count out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // input synchronisers: first flop feeds only the second
    localparam int NIN = 11;
    logic [NIN-1:0] raw, s1, s2;
    assign raw = {en_i, bias_ok_i, main_ok_i, otp_i, fb_ssdone_i,
                  fb_uv_i, fb_ov_i, fb_oob_i, fb_low_i, neg_lim_i, ls_on_i};

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1 <= '0;
            s2 <= '0;
        end else if (ce_i) begin
            s1 <= raw;
            s2 <= s1;
        end
    end

    logic en, bias_ok, main_ok, otp, ssdone, uv, ov, out_of_bounds_clamp, fblow, nlim, lson;
    assign {en, bias_ok, main_ok, otp, ssdone, uv, ov, out_of_bounds_clamp, fblow, nlim,
            lson} = s2;

    ////////////////////////////////////////////////////////////////////
    // power conditions and delay counters
    logic        power_ok;
    logic        in_ss;
    logic        ss_int_done;
    logic        ss_both;
    logic        pg_dly_done;
    logic        pg_bad_done;
    logic        uv_done;
    logic        hic_done;
    logic        pg_latch_low;
    bfs_pkg::bfs_state_e state, next_state;

    // any of these drops the converter and opens discharge
    assign power_ok = en && bias_ok && main_ok && !otp;

    assign in_ss   = (state == bfs_pkg::BFS_SOFTST);
    assign ss_both = ss_int_done && ssdone;

    bfs_delay #(.W(bfs_pkg::CNT_W)) u_ss (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .ce_i    (ce_i),
        .cond_i  (in_ss || state == bfs_pkg::BFS_RUN),
        .limit_i (bfs_pkg::CNT_W'(SS_CYC)),
        .done_o  (ss_int_done)
    );

    bfs_delay #(.W(bfs_pkg::CNT_W)) u_pgd (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .ce_i    (ce_i),
        .cond_i  (state == bfs_pkg::BFS_RUN),
        .limit_i (bfs_pkg::CNT_W'(PGD_CYC)),
        .done_o  (pg_dly_done)
    );

    bfs_delay #(.W(bfs_pkg::CNT_W)) u_pgbad (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .ce_i    (ce_i),
        .cond_i  (state == bfs_pkg::BFS_RUN && (uv || ov)),
        .limit_i (bfs_pkg::CNT_W'(bfs_pkg::PG_GLITCH_CYC)),
        .done_o  (pg_bad_done)
    );

    // undervoltage qualification only after soft-start; clears on recovery
    bfs_delay #(.W(bfs_pkg::CNT_W)) u_uv (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .ce_i    (ce_i),
        .cond_i  (uv && (state == bfs_pkg::BFS_RUN ||
                         state == bfs_pkg::BFS_OVP)),
        .limit_i (bfs_pkg::CNT_W'(bfs_pkg::UV_DELAY_CYC)),
        .done_o  (uv_done)
    );

    bfs_delay #(.W(bfs_pkg::CNT_W)) u_hic (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .ce_i    (ce_i),
        .cond_i  (state == bfs_pkg::BFS_HICCUP),
        .limit_i (bfs_pkg::CNT_W'(HICCUP_CYC)),
        .done_o  (hic_done)
    );

    ////////////////////////////////////////////////////////////////////
    // main sequencer
    always_comb begin
        next_state = state;
        case (state)
            bfs_pkg::BFS_OFF:
                if (power_ok) next_state = bfs_pkg::BFS_SOFTST;
            bfs_pkg::BFS_SOFTST:
                if (!power_ok) next_state = bfs_pkg::BFS_OFF;
                else if (ss_both) next_state = bfs_pkg::BFS_RUN;
            bfs_pkg::BFS_RUN:
                if (!power_ok) next_state = bfs_pkg::BFS_OFF;
                else if (ov) next_state = bfs_pkg::BFS_OVP;
                else if (uv_done) next_state = bfs_pkg::BFS_HICCUP;
            bfs_pkg::BFS_OVP:
                if (!power_ok) next_state = bfs_pkg::BFS_OFF;
                else if (uv_done) next_state = bfs_pkg::BFS_LATCHED;
            bfs_pkg::BFS_HICCUP:
                if (!power_ok) next_state = bfs_pkg::BFS_OFF;
                else if (hic_done) next_state = bfs_pkg::BFS_SOFTST;
            bfs_pkg::BFS_LATCHED:
                // only an enable toggle, supply loss or over-temperature leaves here
                if (!power_ok) next_state = bfs_pkg::BFS_OFF;
            default:
                next_state = bfs_pkg::BFS_OFF;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) state <= bfs_pkg::BFS_OFF;
        else if (ce_i) state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////
    // negative-limit cycle: low off, one on-time, low back on
    logic nl_busy;
    logic cycle_mode;
    assign cycle_mode = (state == bfs_pkg::BFS_OVP) ||
                        (state == bfs_pkg::BFS_RUN && out_of_bounds_clamp);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nl_busy   <= 1'b0;
            ton_req_o <= 1'b0;
        end else if (ce_i) begin
            ton_req_o <= 1'b0;
            if (nl_busy) begin
                if (ton_done_i) nl_busy <= 1'b0;
            end else if (nlim && lson &&
                         (state == bfs_pkg::BFS_RUN || cycle_mode)) begin
                nl_busy   <= 1'b1;
                ton_req_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // gate and discharge requests
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hs_en_o    <= 1'b0;
            ls_force_o <= 1'b0;
            fccm_o     <= 1'b0;
            ss_dis_o   <= 1'b1;
        end else if (ce_i) begin
            // over-voltage keeps high side latched off except the one pulse
            hs_en_o    <= (next_state == bfs_pkg::BFS_SOFTST ||
                           next_state == bfs_pkg::BFS_RUN);
            ls_force_o <= (next_state == bfs_pkg::BFS_OVP) && !nl_busy;
            fccm_o     <= (next_state == bfs_pkg::BFS_RUN && out_of_bounds_clamp) ||
                          next_state == bfs_pkg::BFS_OVP;
            ss_dis_o   <= (next_state != bfs_pkg::BFS_SOFTST &&
                           next_state != bfs_pkg::BFS_RUN);
        end
    end

    // discharge switch runs only while disabled and feedback above 90 mV
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) dis_sw_o <= 1'b0;
        else if (ce_i) dis_sw_o <= !power_ok && !fblow;
    end

    ////////////////////////////////////////////////////////////////////
    // power-good: held low by default, latched low on window fault
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pg_latch_low <= 1'b0;
            pg_output_o  <= bfs_pkg::PG_RST;
        end else if (ce_i) begin
            if (state == bfs_pkg::BFS_OFF) pg_latch_low <= 1'b0;
            else if (pg_bad_done) pg_latch_low <= 1'b1;
            pg_output_o <= pg_dly_done && !pg_latch_low && !pg_bad_done &&
                           state == bfs_pkg::BFS_RUN && ss_both;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_pg_needs_run: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) pg_output_o |-> $past(state) == bfs_pkg::BFS_RUN)
        else $error("power-good high outside run");
    a_pg_latched: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && pg_latch_low) |=> !pg_output_o)
        else $error("power-good high while latched low");
    a_pg_clear_off: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (pg_latch_low && $past(pg_latch_low) &&
        !$past(pg_latch_low, 2)) |-> state != bfs_pkg::BFS_SOFTST)
        else $error("latch set outside monitor");
    a_ovp_hs_off: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && state == bfs_pkg::BFS_OVP &&
        next_state == bfs_pkg::BFS_OVP) |=> !hs_en_o)
        else $error("high side enabled in overvoltage");
    a_latch_stays: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (state == bfs_pkg::BFS_LATCHED && power_ok) |=>
        state == bfs_pkg::BFS_LATCHED)
        else $error("latched-off state left without toggle");
    a_uv_needs_ss: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) in_ss |=> state != bfs_pkg::BFS_HICCUP)
        else $error("hiccup from soft-start");
    // a frozen clock enable holds the pulse, so only enabled edges count
    a_ton_pulse: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && ton_req_o) |=> !ton_req_o)
        else $error("on-time request longer than one cycle");
    a_ss_dis_off: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && !power_ok) |=> ss_dis_o && !hs_en_o)
        else $error("switching while power bad");
    a_dis_low_fb: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && fblow) |=> !dis_sw_o)
        else $error("discharge on below 90 mV");

    // mode outputs and timers against the state that asks for them
    a_oob_fccm: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && out_of_bounds_clamp && state == bfs_pkg::BFS_RUN &&
        next_state == bfs_pkg::BFS_RUN) |=> fccm_o && hs_en_o)
        else $error("out-of-bounds without continuous conduction");
    a_ovp_ls_hold: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && !nl_busy && state == bfs_pkg::BFS_OVP &&
        next_state == bfs_pkg::BFS_OVP) |=> ls_force_o)
        else $error("low side released in overvoltage");
    a_hic_sleep: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && next_state == bfs_pkg::BFS_HICCUP) |=>
        !hs_en_o && ss_dis_o)
        else $error("switching during hiccup sleep");
    a_pg_delay: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && !pg_dly_done) |=> !pg_output_o)
        else $error("power-good before its delay");
    a_uv_timer_clr: assert property (@(posedge clk_i) disable iff
        (!arst_n_i) (ce_i && !uv) |=> !uv_done)
        else $error("undervoltage timer kept after recovery");

    c_pg_high: cover property (@(posedge clk_i) $rose(pg_output_o));
    c_hiccup:  cover property (@(posedge clk_i)
        state == bfs_pkg::BFS_HICCUP);
    c_latched: cover property (@(posedge clk_i)
        state == bfs_pkg::BFS_LATCHED);
    c_oob:     cover property (@(posedge clk_i) fccm_o && hs_en_o);
endmodule
